// >>> common/opc_pkg.sv
/*
 Package for the oscillator phase and frequency control block: widths, command codes,
 timing constants and the packed structs carried between the sequencer and the block.
 Assumes a single 100 MHz clock domain.
*/
`default_nettype none
package opc_pkg;
   localparam int unsigned N_OSC       = 8;
   localparam int unsigned OSC_IDX_W   = 3;
   localparam int unsigned PHASE_W     = 32;
   localparam int unsigned FREQ_W      = 32;
   localparam int unsigned STEP_W      = 20;
   localparam int unsigned LUT_AW      = 8;
   localparam int unsigned SINE_W      = 16;
   localparam int unsigned HARM_W      = 4;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned FREQ_UPD_NS = 100;
   localparam int unsigned FREQ_UPD_CYC = FREQ_UPD_NS / CLK_PERIOD_NS;
   localparam int unsigned UPD_CNT_W   = 4;
   localparam logic [UPD_CNT_W-1:0] UPD_CNT_LAST = UPD_CNT_W'(FREQ_UPD_CYC - 1);
   localparam logic [N_OSC-1:0]     ALL_OSC_MASK = 8'hff;
   localparam logic [PHASE_W-1:0]   PHASE_ZERO   = 32'h0000_0000;
   localparam logic [FREQ_W-1:0]    FREQ_ZERO    = 32'h0000_0000;
   localparam logic [HARM_W-1:0]    HARM_ONE     = 4'h1;
   localparam logic [3:0]           LUT_HEAD_W   = 4'h8;

   typedef enum logic [2:0]
   {
      OPC_CMD_CLEAR_PHASES,
      OPC_CMD_SET_PHASE,
      OPC_CMD_STEP_PHASE,
      OPC_CMD_LOAD_FREQ,
      OPC_CMD_ARM_RAMP,
      OPC_CMD_RAMP_STEP,
      OPC_CMD_SELECT_OSC,
      OPC_CMD_SET_HARMONIC
   } opc_cmd_t;

   typedef struct packed
   {
      opc_cmd_t               op;
      logic [OSC_IDX_W-1:0]   osc;
      logic                   use_mask;
      logic [N_OSC-1:0]       mask;
      logic [PHASE_W-1:0]     phase;
      logic [FREQ_W-1:0]      freq;
      logic [FREQ_W-1:0]      incr;
      logic [STEP_W-1:0]      step;
   } opc_cmd_pkt_t;

   typedef struct packed
   {
      logic                   valid;
      logic                   start;
      logic                   done;
   } opc_play_t;

   typedef struct packed
   {
      logic [SINE_W-1:0]      sine;
      logic [SINE_W-1:0]      cosine;
      logic [PHASE_W-1:0]     phase;
   } opc_carrier_t;
endpackage : opc_pkg
`default_nettype wire

// >>> design/opc_accum.sv
/*
 One phase accumulator. Advances by its frequency word every enabled cycle and
 clears when asked. Assumes the clock enable is driven by the parent.
*/
`default_nettype none
module opc_accum
   import opc_pkg::*;
(
   input  wire logic               clk,      // Sample clock
   input  wire logic               rst_n,    // Async reset, active low
   input  wire logic               clk_en,   // Freezes state when low
   input  wire logic               clear,    // Clear phase this cycle
   input  wire logic [FREQ_W-1:0]  freq,     // Phase increment per cycle
   output var  logic [PHASE_W-1:0] phase     // Accumulated phase
);
   import opc_pkg::*;

   typedef struct packed
   {
      logic [PHASE_W-1:0] acc;
   } opc_acc_state_t;

   opc_acc_state_t s_q;
   opc_acc_state_t s_d;

   always_comb
   begin
      s_d = s_q;
      if (clear)
      begin
         s_d.acc = PHASE_ZERO;
      end
      else
      begin
         s_d.acc = s_q.acc + freq;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q <= '0;
      end
      else if (clk_en)
      begin
         s_q <= s_d;
      end
   end

   assign phase = s_q.acc;
endmodule : opc_accum
`default_nettype wire

// >>> design/opc_osc_ctrl.sv
/*
 Oscillator phase and frequency control for one generator channel: eight phase
 accumulators, one selected into a sine generator with phase offset and harmonic,
 real-time phase set/step and frequency load/ramp commands from the sequencer.
 Assumes the sequencer holds cmd_valid until cmd_ready and flags playback start/end.
*/
`default_nettype none
module opc_osc_ctrl
   import opc_pkg::*;
(
   input  wire logic         clk,        // Sample clock, 100 MHz
   input  wire logic         rst_n,      // Async reset, active low
   input  wire logic         clk_en,     // Freezes all state when low
   input  wire opc_cmd_pkt_t cmd,        // Command from the sequencer
   input  wire logic         cmd_valid,  // Command present
   output var  logic         cmd_ready,  // Command accepted this cycle
   input  wire opc_play_t    play,       // Playback start request and end flag
   output var  logic         play_go,    // Playback may start this cycle
   output var  logic         freq_busy,  // Frequency update in progress
   output var  opc_carrier_t carrier     // Sine generator output
);
   import opc_pkg::*;

   // ==========================================================
   // State
   typedef enum logic [1:0]
   {
      OPC_FS_IDLE,
      OPC_FS_MUL,
      OPC_FS_WAIT
   } opc_fstate_t;

   typedef struct packed
   {
      opc_fstate_t                     fs;
      logic [UPD_CNT_W-1:0]            cnt;
      logic [OSC_IDX_W-1:0]            tgt;
      logic [FREQ_W-1:0]               new_freq;
      logic [N_OSC-1:0][FREQ_W-1:0]    freq;
      logic [N_OSC-1:0][FREQ_W-1:0]    ramp_start;
      logic [N_OSC-1:0][FREQ_W-1:0]    ramp_incr;
      logic [PHASE_W-1:0]              offset;
      logic [PHASE_W-1:0]              step_pend;
      logic                            step_has;
      logic [OSC_IDX_W-1:0]            sel;
      logic [HARM_W-1:0]               harm;
      logic [N_OSC-1:0]                clr;
      opc_carrier_t                    out;
   } opc_state_t;

   opc_state_t s_q;
   opc_state_t s_d;

   logic [N_OSC-1:0][PHASE_W-1:0] acc_phase;
   logic [PHASE_W-1:0]            gen_phase;
   logic [LUT_AW-1:0]             lut_idx;
   logic                          take;
   logic                          freq_cmd;

   // ==========================================================
   // Oscillators
   generate
      for (genvar g = 0; g < N_OSC; g++)
      begin : g_osc
         opc_accum opc_accum_i
         (
            .clk   (clk),
            .rst_n (rst_n),
            .clk_en(clk_en),
            .clear (s_q.clr[g]),
            .freq  (s_q.freq[g]),
            .phase (acc_phase[g])
         );
      end
   endgenerate

   // ==========================================================
   // Sine lookup: quarter-period table mirrored and negated over one full period
   localparam logic [SINE_W-1:0] SINE_PEAK = 16'h7fff;

   function automatic logic [SINE_W-1:0] opc_quarter(input logic [LUT_AW-3:0] q);
      unique case (q)
         6'h00: opc_quarter = 16'h0000;
         6'h01: opc_quarter = 16'h0324;
         6'h02: opc_quarter = 16'h0648;
         6'h03: opc_quarter = 16'h096a;
         6'h04: opc_quarter = 16'h0c8c;
         6'h05: opc_quarter = 16'h0fab;
         6'h06: opc_quarter = 16'h12c8;
         6'h07: opc_quarter = 16'h15e2;
         6'h08: opc_quarter = 16'h18f9;
         6'h09: opc_quarter = 16'h1c0b;
         6'h0a: opc_quarter = 16'h1f1a;
         6'h0b: opc_quarter = 16'h2223;
         6'h0c: opc_quarter = 16'h2528;
         6'h0d: opc_quarter = 16'h2826;
         6'h0e: opc_quarter = 16'h2b1f;
         6'h0f: opc_quarter = 16'h2e11;
         6'h10: opc_quarter = 16'h30fb;
         6'h11: opc_quarter = 16'h33df;
         6'h12: opc_quarter = 16'h36ba;
         6'h13: opc_quarter = 16'h398c;
         6'h14: opc_quarter = 16'h3c56;
         6'h15: opc_quarter = 16'h3f17;
         6'h16: opc_quarter = 16'h41ce;
         6'h17: opc_quarter = 16'h447a;
         6'h18: opc_quarter = 16'h471c;
         6'h19: opc_quarter = 16'h49b4;
         6'h1a: opc_quarter = 16'h4c3f;
         6'h1b: opc_quarter = 16'h4ebf;
         6'h1c: opc_quarter = 16'h5133;
         6'h1d: opc_quarter = 16'h539a;
         6'h1e: opc_quarter = 16'h55f5;
         6'h1f: opc_quarter = 16'h5842;
         6'h20: opc_quarter = 16'h5a82;
         6'h21: opc_quarter = 16'h5cb3;
         6'h22: opc_quarter = 16'h5ed7;
         6'h23: opc_quarter = 16'h60eb;
         6'h24: opc_quarter = 16'h62f1;
         6'h25: opc_quarter = 16'h64e8;
         6'h26: opc_quarter = 16'h66cf;
         6'h27: opc_quarter = 16'h68a6;
         6'h28: opc_quarter = 16'h6a6d;
         6'h29: opc_quarter = 16'h6c23;
         6'h2a: opc_quarter = 16'h6dc9;
         6'h2b: opc_quarter = 16'h6f5e;
         6'h2c: opc_quarter = 16'h70e2;
         6'h2d: opc_quarter = 16'h7254;
         6'h2e: opc_quarter = 16'h73b5;
         6'h2f: opc_quarter = 16'h7504;
         6'h30: opc_quarter = 16'h7641;
         6'h31: opc_quarter = 16'h776b;
         6'h32: opc_quarter = 16'h7883;
         6'h33: opc_quarter = 16'h7989;
         6'h34: opc_quarter = 16'h7a7c;
         6'h35: opc_quarter = 16'h7b5c;
         6'h36: opc_quarter = 16'h7c29;
         6'h37: opc_quarter = 16'h7ce3;
         6'h38: opc_quarter = 16'h7d89;
         6'h39: opc_quarter = 16'h7e1d;
         6'h3a: opc_quarter = 16'h7e9c;
         6'h3b: opc_quarter = 16'h7f09;
         6'h3c: opc_quarter = 16'h7f61;
         6'h3d: opc_quarter = 16'h7fa6;
         6'h3e: opc_quarter = 16'h7fd8;
         6'h3f: opc_quarter = 16'h7ff5;
      endcase
   endfunction : opc_quarter

   function automatic logic [SINE_W-1:0] opc_sine(input logic [LUT_AW-1:0] idx);
      logic [LUT_AW-3:0] q;
      logic [LUT_AW-3:0] qm;
      logic [SINE_W-1:0] mag;
      q  = idx[LUT_AW-3:0];
      qm = -q;
      // Odd quadrants read the table backwards; the peak itself has no entry
      if (!idx[LUT_AW-2])
      begin
         mag = opc_quarter(q);
      end
      else if (q == '0)
      begin
         mag = SINE_PEAK;
      end
      else
      begin
         mag = opc_quarter(qm);
      end
      opc_sine = idx[LUT_AW-1] ? SINE_W'(~mag + 16'h0001) : mag;
   endfunction : opc_sine

   assign freq_cmd  = (cmd.op == OPC_CMD_LOAD_FREQ) || (cmd.op == OPC_CMD_RAMP_STEP);
   // Frequency commands wait while an update is still running
   assign cmd_ready = clk_en && !(freq_cmd && s_q.fs != OPC_FS_IDLE);
   assign take      = cmd_valid && cmd_ready;
   assign play_go   = play.start && s_q.fs == OPC_FS_IDLE && !(take && freq_cmd);
   assign freq_busy = s_q.fs != OPC_FS_IDLE;
   assign carrier   = s_q.out;

   // Selected oscillator times harmonic, plus offset
   assign gen_phase = PHASE_W'(acc_phase[s_q.sel] * s_q.harm) + s_q.offset;
   assign lut_idx   = gen_phase[PHASE_W-1 -: LUT_AW];

   // ==========================================================
   // Next state
   always_comb
   begin
      s_d     = s_q;
      s_d.clr = '0;

      // Deferred step applied at the end of the playback in flight
      if (play.done)
      begin
         if (s_q.step_has)
         begin
            s_d.offset    = s_q.offset + s_q.step_pend;
            s_d.step_pend = PHASE_ZERO;
            s_d.step_has  = 1'b0;
         end
      end

      unique case (s_q.fs)
         OPC_FS_IDLE:
         begin
         end
         OPC_FS_MUL:
         begin
            s_d.fs = OPC_FS_WAIT;
            s_d.cnt = s_q.cnt + 4'h1;
         end
         OPC_FS_WAIT:
         begin
            if (s_q.cnt == UPD_CNT_LAST)
            begin
               s_d.freq[s_q.tgt] = s_q.new_freq;
               s_d.fs            = OPC_FS_IDLE;
            end
            else
            begin
               s_d.cnt = s_q.cnt + 4'h1;
            end
         end
      endcase

      if (take)
      begin
         unique case (cmd.op)
            OPC_CMD_CLEAR_PHASES:
            begin
               s_d.clr = cmd.use_mask ? cmd.mask : ALL_OSC_MASK;
            end
            OPC_CMD_SET_PHASE:
            begin
               s_d.offset = cmd.phase;
            end
            OPC_CMD_STEP_PHASE:
            begin
               // A step coinciding with playback end still accumulates
               s_d.step_pend = s_d.step_pend + cmd.phase;
               s_d.step_has  = 1'b1;
            end
            OPC_CMD_LOAD_FREQ:
            begin
               s_d.tgt      = cmd.osc;
               s_d.new_freq = cmd.freq;
               s_d.cnt      = '0;
               s_d.fs       = OPC_FS_WAIT;
            end
            OPC_CMD_ARM_RAMP:
            begin
               s_d.ramp_start[cmd.osc] = cmd.freq;
               s_d.ramp_incr[cmd.osc]  = cmd.incr;
            end
            OPC_CMD_RAMP_STEP:
            begin
               s_d.tgt      = cmd.osc;
               s_d.new_freq = s_q.ramp_start[cmd.osc]
                            + FREQ_W'(s_q.ramp_incr[cmd.osc] * cmd.step);
               s_d.cnt      = '0;
               s_d.fs       = OPC_FS_MUL;
            end
            OPC_CMD_SELECT_OSC:
            begin
               s_d.sel = cmd.osc;
            end
            OPC_CMD_SET_HARMONIC:
            begin
               s_d.harm = cmd.phase[HARM_W-1:0];
            end
         endcase
      end

      s_d.out.phase  = gen_phase;
      s_d.out.sine   = opc_sine(lut_idx);
      s_d.out.cosine = opc_sine(LUT_AW'(lut_idx + 8'h40));
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q      <= '0;
         s_q.fs   <= OPC_FS_IDLE;
         s_q.harm <= HARM_ONE;
      end
      else if (clk_en)
      begin
         s_q <= s_d;
      end
   end
endmodule : opc_osc_ctrl
`default_nettype wire

// >>> bench/opc_osc_ctrl_asserts.sv
/* Port checker for opc_osc_ctrl.
   Bound into every instance; sees only the top ports. */
`default_nettype none
module opc_osc_ctrl_chk
   import opc_pkg::*;
(
   input wire logic         clk,       // Clock
   input wire logic         rst_n,     // Reset, low
   input wire logic         clk_en,    // Run enable
   input wire opc_cmd_pkt_t cmd,       // Command
   input wire logic         cmd_valid, // Command present
   input wire logic         cmd_ready, // Command taken
   input wire opc_play_t    play,      // Playback flags
   input wire logic         play_go,   // Start grant
   input wire logic         freq_busy, // Update running
   input wire opc_carrier_t carrier    // Output
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic is_f = cmd.op inside {OPC_CMD_LOAD_FREQ, OPC_CMD_RAMP_STEP};
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========
   // Sequences
   sequence s_ftake;
      cmd_valid && cmd_ready && is_f;
   endsequence
   sequence s_run;
      freq_busy[*8] ##1 freq_busy[*2];
   endsequence
   // ==========
   // Checks
   AST_BUSY_START: assert property (s_ftake |=> freq_busy)
      else $error("busy missing after frequency command");
   AST_BUSY_LEN: assert property ($rose(freq_busy) |-> s_run ##1 !freq_busy)
      else $error("frequency update length wrong");
   AST_REFUSE: assert property (freq_busy && cmd_valid && is_f |-> !cmd_ready)
      else $error("frequency command taken while busy");
   AST_TAKE_OTHER: assert property (clk_en && cmd_valid && !is_f |-> cmd_ready)
      else $error("phase command not taken");
   AST_NO_GO_BUSY: assert property (freq_busy |-> !play_go)
      else $error("playback started during update");
   AST_GO_START: assert property (play_go |-> play.start)
      else $error("grant without request");
   AST_GO_FREE: assert property (play.start && !freq_busy && !(cmd_valid && cmd_ready && is_f) |-> play_go)
      else $error("idle playback request not granted");
   AST_FROZEN: assert property (!clk_en |=> $stable(carrier) && $stable(freq_busy))
      else $error("state moved while frozen");
endmodule : opc_osc_ctrl_chk
bind opc_osc_ctrl opc_osc_ctrl_chk opc_osc_ctrl_chk_i (.clk, .rst_n, .clk_en, .cmd, .cmd_valid, .cmd_ready,
   .play, .play_go, .freq_busy, .carrier);
`default_nettype wire

// >>> bench/opc_seq_model.sv
/* Behavioural playback unit of the sequencer.
   Assumes the bench pulses req for one cycle per waveform. */
`default_nettype none
module opc_seq_model
   import opc_pkg::*;
#(
   parameter int LEN = 6  // Playback cycles
)
(
   input  wire logic      clk,   // Clock
   input  wire logic      rst_n, // Reset, low
   input  wire logic      req,   // Ask for playback
   input  wire logic      go,    // Start grant
   output var  opc_play_t play   // Start and end flags
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         play <= '0;
         cnt  <= 0;
      end
      else
      begin
         play.start <= go ? 1'b0 : (play.start | req);
         play.done  <= cnt == 1;
         play.valid <= cnt > 1;
         if (play.start && go)
            cnt <= LEN;
         else if (cnt > 0)
            cnt <= cnt - 1;
      end
   end
endmodule : opc_seq_model
`default_nettype wire

// >>> bench/tb_opc_osc_ctrl.sv
/* Bench for opc_osc_ctrl with the playback model; checker by bind.
   Angles are 32-bit full-turn units, harmonic raised to two at the end. */
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
   $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_opc_osc_ctrl
   import opc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic         clk, cmd_ready, play_go, freq_busy;
   logic         rst_n = 0, clk_en = 1, cmd_valid = 0, req = 0;
   opc_cmd_pkt_t cmd = '0;
   opc_play_t    play;
   opc_carrier_t carrier;
   int           error_cnt = 0, n_tests = 0;
   logic [31:0]  p;
   localparam logic [31:0] OFF = 32'h6000_0000;
   opc_osc_ctrl opc_osc_ctrl_i (.clk, .rst_n, .clk_en, .cmd, .cmd_valid, .cmd_ready, .play, .play_go,
      .freq_busy, .carrier);
   opc_seq_model opc_seq_model_i (.clk, .rst_n, .req, .go(play_go), .play);
   // ==========
   // Helpers
   task automatic tick(int n);
      repeat (n) @(posedge clk) #1;
   endtask : tick
   task automatic send(opc_cmd_t op, logic [2:0] o, logic [31:0] a, logic [31:0] b = '0,
      logic [19:0] s = '0, logic [7:0] m = '0);
      cmd = '{op, o, m != 8'h00, m, a, a, b, s};
      cmd_valid = 1'b1;
      #1;
      while (cmd_ready !== 1'b1)
         tick(1);
      tick(1);
      cmd_valid = 1'b0;
      tick(1);
   endtask : send
   task automatic wait_done();
      for (int n = 0; n < 40 && play.done !== 1'b1; n++)
         tick(1);
   endtask : wait_done
   task automatic rate(string nm, logic [31:0] e);
      p = carrier.phase;
      tick(1);
      `CHK(nm, e, carrier.phase - p)
   endtask : rate
   // ==========
   // Scenarios
   task automatic t_phase();
      send(OPC_CMD_SET_PHASE, 3'd0, 32'h2000_0000);
      send(OPC_CMD_STEP_PHASE, 3'd0, 32'h4000_0000);
      tick(5);
      `CHK("set_phase", 32'h2000_0000, carrier.phase)
      `CHK("sine_45", carrier.cosine, carrier.sine)
      req = 1'b1;
      tick(1);
      req = 1'b0;
      wait_done();
      tick(3);
      `CHK("step_phase", OFF, carrier.phase)
      `CHK("sine_135", 2'b01, {carrier.sine[SINE_W-1], carrier.cosine[SINE_W-1]})
   endtask : t_phase
   task automatic t_freq();
      int n;
      send(OPC_CMD_LOAD_FREQ, 3'd0, 32'h1000);
      req = 1'b1;
      for (n = 0; n < 20 && freq_busy === 1'b1; n++)
      begin
         `CHK("go_in_busy", 1'b0, play_go)
         tick(1);
         req = 1'b0;
      end
      // One busy cycle passes inside send
      `CHK("busy_cycles", FREQ_UPD_CYC - 1, n)
      wait_done();
      `CHK("played", 1'b1, play.done)
      rate("freq_rate", 32'h1000);
      clk_en = 1'b0;
      p = carrier.phase;
      tick(3);
      `CHK("frozen", p, carrier.phase)
      clk_en = 1'b1;
   endtask : t_freq
   task automatic t_clear();
      send(OPC_CMD_SELECT_OSC, 3'd1, '0);
      send(OPC_CMD_LOAD_FREQ, 3'd1, 32'h100);
      tick(40);
      send(OPC_CMD_CLEAR_PHASES, 3'd0, '0, '0, '0, 8'h05);
      tick(3);
      `CHK("mask_keep", 1'b1, carrier.phase - OFF > 32'h2000)
      send(OPC_CMD_SELECT_OSC, 3'd0, '0);
      tick(3);
      `CHK("mask_clr", 1'b1, carrier.phase - OFF < 32'h1_0000)
      send(OPC_CMD_SELECT_OSC, 3'd1, '0);
      send(OPC_CMD_CLEAR_PHASES, 3'd0, '0);
      tick(3);
      `CHK("clr_all", 1'b1, carrier.phase - OFF < 32'h800)
   endtask : t_clear
   task automatic t_ramp();
      send(OPC_CMD_ARM_RAMP, 3'd2, 32'h200, 32'h10);
      send(OPC_CMD_ARM_RAMP, 3'd3, 32'h40, 32'h1);
      send(OPC_CMD_RAMP_STEP, 3'd2, '0, '0, 20'd5);
      send(OPC_CMD_RAMP_STEP, 3'd3, '0, '0, 20'd2);
      tick(12);
      send(OPC_CMD_SELECT_OSC, 3'd2, '0);
      rate("ramp_osc2", 32'h250);
      send(OPC_CMD_SELECT_OSC, 3'd3, '0);
      rate("ramp_osc3", 32'h42);
      send(OPC_CMD_SET_HARMONIC, 3'd0, 32'h2);
      rate("harmonic", 32'h84);
   endtask : t_ramp
   task automatic report_and_stop();
      if (error_cnt == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   // ==========
   // Run
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      repeat (20) @(posedge clk);
      #1 rst_n = 1'b1;
      tick(1);
      t_phase();
      t_freq();
      t_clear();
      t_ramp();
      report_and_stop();
   end
   initial
   begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      report_and_stop();
   end
endmodule : tb_opc_osc_ctrl
`default_nettype wire
